/* File: hdl/ldcc_regs.v */
// Purpose: apb register bank for the first and second led drive settings
// Assumes: ref_clk 20 MHz, rst synchronous active high
// Notes: zero wait state apb; unmapped addresses answer pslverr
`include "ldcc_defines.vh"

module ldcc_regs #(
    parameter ADDR_W = 10
) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg led_one_strength_select,
    output reg [2:0] led_one_edge_rate,
    output reg [3:0] led_one_coarse_current,
    output reg [4:0] led_one_fine_trim,
    output reg led_two_strength_select,
    output reg [2:0] led_two_edge_rate,
    output reg [3:0] led_two_coarse_current,
    output reg [4:0] led_two_fine_trim,
    output reg first_led_low_power,
    output reg second_led_low_power
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg [15:0] led_one_drive_config_r;
    reg [15:0] led_two_drive_config_r;
    reg [15:0] fine_adjust_r;
    reg [1:0] sel_nxt;
    reg hit_nxt;
    reg [31:0] rd_nxt;
    wire setup_w;
    wire access_w;
    wire wr_w;
    wire wr_one_w;
    wire wr_two_w;
    wire wr_fine_w;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // full decode; unmapped words answer with pslverr
    function [1:0] ldcc_decode;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `LDCC_ADDR_LED_ONE: ldcc_decode = 2'h1;
                `LDCC_ADDR_LED_TWO: ldcc_decode = 2'h2;
                `LDCC_ADDR_FINE: ldcc_decode = 2'h3;
                default: ldcc_decode = 2'h0;
            endcase
        end
    endfunction

    always @* begin
        sel_nxt = ldcc_decode(paddr);
        hit_nxt = (sel_nxt != 2'h0);
    end

    // ------------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------------
    // a write lands only at the edge where the master sees pready high
    assign setup_w = psel & ~penable;
    assign access_w = psel & penable & pready;
    assign wr_w = access_w & pwrite & hit_nxt;
    assign wr_one_w = wr_w & (sel_nxt == 2'h1);
    assign wr_two_w = wr_w & (sel_nxt == 2'h2);
    assign wr_fine_w = wr_w & (sel_nxt == 2'h3);

    // ------------------------------------------------------------------
    // led one register
    // ------------------------------------------------------------------
    // reserved bits are stored as written, software keeps them
    always @(posedge ref_clk) begin
        if (rst) begin
            led_one_drive_config_r <= `LDCC_RST_LED_CFG;
        end else if (wr_one_w) begin
            led_one_drive_config_r <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // led two register
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            led_two_drive_config_r <= `LDCC_RST_LED_CFG;
        end else if (wr_two_w) begin
            led_two_drive_config_r <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // fine adjust register
    // ------------------------------------------------------------------
    // bit 5 is reserved and always reads zero
    always @(posedge ref_clk) begin
        if (rst) begin
            fine_adjust_r <= `LDCC_RST_FINE;
        end else if (wr_fine_w) begin
            fine_adjust_r <= pwdata[15:0] & `LDCC_FINE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // read data select
    // ------------------------------------------------------------------
    always @* begin
        case (sel_nxt)
            2'h1: rd_nxt = {16'h0000, led_one_drive_config_r};
            2'h2: rd_nxt = {16'h0000, led_two_drive_config_r};
            2'h3: rd_nxt = {16'h0000, fine_adjust_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    // every setup is answered in the next cycle, no extra wait
    always @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_w;
        end
    end

    // prdata holds until the next read
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (setup_w & ~pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // apb error answer
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_w & ~hit_nxt;
        end
    end

    // ------------------------------------------------------------------
    // led one drive outputs
    // ------------------------------------------------------------------
    // registered copies, one cycle behind the storage
    // scale = 0.4 + 0.6 * bit; zero also means low power
    always @(posedge ref_clk) begin
        if (rst) begin
            led_one_strength_select <= 1'b1;
            first_led_low_power <= 1'b0;
            led_one_edge_rate <= 3'h0;
            led_one_coarse_current <= 4'h0;
            led_one_fine_trim <= 5'h0C;
        end else begin
            led_one_strength_select <=
                led_one_drive_config_r[`LDCC_SCALE_BIT];
            first_led_low_power <=
                ~led_one_drive_config_r[`LDCC_SCALE_BIT];
            // slower codes ease overvoltage stress at the driver
            led_one_edge_rate <= led_one_drive_config_r
                [`LDCC_SLEW_HI:`LDCC_SLEW_LO];
            led_one_coarse_current <= led_one_drive_config_r
                [`LDCC_COARSE_HI:`LDCC_COARSE_LO];
            led_one_fine_trim <= fine_adjust_r
                [`LDCC_FINE_ONE_HI:`LDCC_FINE_ONE_LO];
        end
    end

    // ------------------------------------------------------------------
    // led two drive outputs
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            led_two_strength_select <= 1'b1;
            second_led_low_power <= 1'b0;
            led_two_edge_rate <= 3'h0;
            led_two_coarse_current <= 4'h0;
            led_two_fine_trim <= 5'h0C;
        end else begin
            led_two_strength_select <=
                led_two_drive_config_r[`LDCC_SCALE_BIT];
            second_led_low_power <=
                ~led_two_drive_config_r[`LDCC_SCALE_BIT];
            // slower codes ease overvoltage stress at the driver
            led_two_edge_rate <= led_two_drive_config_r
                [`LDCC_SLEW_HI:`LDCC_SLEW_LO];
            led_two_coarse_current <= led_two_drive_config_r
                [`LDCC_COARSE_HI:`LDCC_COARSE_LO];
            led_two_fine_trim <= fine_adjust_r
                [`LDCC_FINE_TWO_HI:`LDCC_FINE_TWO_LO];
        end
    end

endmodule

/* File: hdl/ldcc_defines.vh */
// Purpose: constants for the led drive current configuration registers
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: printed offsets are register indices; byte address is index * 4
`ifndef LDCC_DEFINES_VH
`define LDCC_DEFINES_VH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define LDCC_IDX_LED_ONE 8'h23
`define LDCC_IDX_LED_TWO 8'h24
`define LDCC_IDX_FINE 8'h25
`define LDCC_ADDR_LED_ONE 10'h08C
`define LDCC_ADDR_LED_TWO 10'h090
`define LDCC_ADDR_FINE 10'h094

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LDCC_SCALE_BIT 13
`define LDCC_RSVD_ONE_BIT 12
`define LDCC_SLEW_HI 6
`define LDCC_SLEW_LO 4
`define LDCC_COARSE_HI 3
`define LDCC_COARSE_LO 0
`define LDCC_FINE_ONE_HI 4
`define LDCC_FINE_ONE_LO 0
`define LDCC_FINE_TWO_HI 10
`define LDCC_FINE_TWO_LO 6
`define LDCC_FINE_THREE_HI 15
`define LDCC_FINE_THREE_LO 11

// ----------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------
`define LDCC_RST_LED_CFG 16'h3000
`define LDCC_RST_FINE 16'h630C
`define LDCC_LED_CFG_MASK 16'hFFFF
`define LDCC_FINE_MASK 16'hFFDF

`endif

/* File: test/ldcc_regs_assertions.sv */
// Purpose: apb timing and drive output checks
// Assumes: zero wait apb, outputs lag registers by one clock
// Notes: bound to every ldcc_regs instance
`include "ldcc_defines.vh"
// ----
// checker
// ----
module ldcc_regs_chk #(
    parameter ADDR_W = 10
) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire led_one_strength_select,
    input wire [3:0] led_one_coarse_current,
    input wire led_two_strength_select,
    input wire [3:0] led_two_coarse_current,
    input wire first_led_low_power,
    input wire second_led_low_power
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire hit = paddr == `LDCC_ADDR_LED_ONE || paddr == `LDCC_ADDR_LED_TWO
        || paddr == `LDCC_ADDR_FINE;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wr_s(logic [ADDR_W-1:0] a);
        setup_s and (pwrite && paddr == a);
    endsequence
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    rdy_answer_a: assert property (setup_s |=> pready)
        else $error("no answer after setup");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    bad_addr_a: assert property (setup_s and (!hit && !pwrite)
        |=> pslverr && prdata == 32'h0) else $error("unmapped read");
    lp_one_a: assert property (
        first_led_low_power == !led_one_strength_select)
        else $error("led one low power wrong");
    lp_two_a: assert property (
        second_led_low_power == !led_two_strength_select)
        else $error("led two low power wrong");
    wr_one_a: assert property (wr_s(`LDCC_ADDR_LED_ONE) |-> ##3
        led_one_coarse_current == $past(pwdata[3:0], 3) &&
        led_one_strength_select == $past(pwdata[13], 3))
        else $error("led one write not applied");
    wr_two_a: assert property (wr_s(`LDCC_ADDR_LED_TWO) |-> ##3
        led_two_coarse_current == $past(pwdata[3:0], 3) &&
        led_two_strength_select == $past(pwdata[13], 3))
        else $error("led two write not applied");
    rst_val_a: assert property ($past(rst) |->
        led_two_strength_select && led_two_coarse_current == 4'h0)
        else $error("led two reset value");
endmodule
bind ldcc_regs ldcc_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .led_one_strength_select, .led_one_coarse_current,
    .led_two_strength_select, .led_two_coarse_current,
    .first_led_low_power, .second_led_low_power);

/* File: test/led_drive_current_config_regs_bench.sv */
// Purpose: register and drive output tests over apb
// Assumes: ref_clk 50 ns, sync reset held four cycles
// Notes: unmapped access expected to be refused
`include "ldcc_defines.vh"
module led_drive_current_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic pready, pslverr, err, s1, s2, lp1, lp2;
    logic [2:0] e1, e2;
    logic [3:0] c1, c2;
    logic [4:0] t1, t2;
    logic [17:0] x, y;
    int err_total = 0, n_tests = 0, cyc = 0;
    ldcc_regs u_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .led_one_strength_select(s1),
        .led_one_edge_rate(e1), .led_one_coarse_current(c1),
        .led_one_fine_trim(t1), .led_two_strength_select(s2),
        .led_two_edge_rate(e2), .led_two_coarse_current(c2),
        .led_two_fine_trim(t2), .first_led_low_power(lp1),
        .second_led_low_power(lp2));
    // ----
    // tasks
    // ----
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic w, input logic [9:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task complete_run();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, `LDCC_ADDR_LED_ONE, 32'h0);
        chk("one rst", rd, 32'h3000);
        xfer(1'b0, `LDCC_ADDR_LED_TWO, 32'h0);
        chk("two rst", rd, 32'h3000);
        chk("ports rst", {s1, s2, lp1, lp2, e1, e2, c1, c2, t1, t2},
            {4'hC, 14'h0, 10'h18C});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            // reserved bits kept: 12 set, others clear
            d = 32'h1000 + i * 32'h10 + 32'hF - i + (i % 2) * 32'h2000;
            xfer(1'b1, `LDCC_ADDR_LED_ONE, d);
            xfer(1'b1, `LDCC_ADDR_LED_TWO, d ^ 32'h2000);
            @(posedge ref_clk);
            x = {i[0], ~i[0], i[2:0], 4'(15 - i), ~i[0], i[0], i[2:0],
                4'(15 - i)};
            #1 y = {s1, lp1, e1, c1, s2, lp2, e2, c2};
            chk("drive", y, x);
            xfer(1'b0, `LDCC_ADDR_LED_ONE, 32'h0);
            chk("one rd", rd, d);
        end
        $display("test drive done");
        xfer(1'b1, `LDCC_ADDR_FINE, 32'h03FF);
        xfer(1'b0, `LDCC_ADDR_FINE, 32'h0);
        chk("fine rd", rd, 32'h03DF);
        chk("trim", {t1, t2}, 10'h3EF);
        $display("test fine done");
        xfer(1'b1, 10'h0A0, 32'hFFFF);
        chk("werr", err, 1'b1);
        xfer(1'b0, 10'h0A0, 32'h0);
        chk("rerr", {err, rd[30:0]}, 32'h80000000);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, `LDCC_ADDR_LED_TWO, 32'h0);
        chk("two rerst", rd, 32'h3000);
        $display("test refuse done");
        complete_run();
    end
endmodule
